/* usb_dev_regblock.sv */
// usb device register block: endpoint results and status, port choice, interrupt enables
// assumes an ahb-lite master, a serial engine reporting transactions on clk, async vbus/id pins
`timescale 1ns/100ps
`include "usb_dev_regs.svh"
module usb_dev_regblock
  import usb_dev_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial engine reports
  input wire pkt_rpt_t pkt,
  input wire engine_evt_t [1:0] evt,
  // otg pins of the first engine's primary port
  input wire logic vbus_valid_pin,
  input wire logic otg_id_pin,
  // port routing, one bit per engine, high picks the secondary port
  output logic [1:0] port_sel_b,
  // interrupt request pulses per engine
  output irq_t [1:0] irq_req
);

  typedef struct packed {
    bus_state_t bus;
    logic wr;
    logic [15:0] addr;
    logic [31:0] rdata;
    logic [1:0][15:0] port;
    logic [1:0][15:0] irqen;
    logic [1:0][15:0] period;
    logic [1:0][15:0] tmo;
    logic [1:0][15:0] frame;
    irq_t [1:0] irq;
  } ctl_t;

  ctl_t st_q;
  ctl_t st_d;

  logic [1:0] mem_we;
  logic [3:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic [31:0] mem_rdata;
  logic [1:0] pin_edge;
  logic [1:0] pin_level;
  logic [1:0] tmo_hit;
  logic accept;
  logic overflow;
  logic underflow;
  logic done_evt;

  // byte difference, sign bits forced on overflow
  function automatic logic [15:0] len_diff(input logic [9:0] armed, input logic [10:0] rx);
    logic [15:0] d;
    d = {6'h00, armed} - {5'h00, rx};
    if (rx > {1'b0, armed}) begin
      d[15:10] = `OVF_SIGN_ONES;
    end
    return d;
  endfunction : len_diff

  // status word of one finished transaction
  function automatic logic [15:0] status_word(input pkt_rpt_t p);
    logic [15:0] s;
    s = 16'h0000;
    s[`ST_ACK] = p.ack;
    s[`ST_ERR] = p.error;
    s[`ST_TMO] = p.timeout;
    s[`ST_SEQ] = p.seq;
    s[`ST_SETUP] = p.setup;
    s[`ST_NAK] = p.nak;
    s[`ST_STALL] = p.stall;
    s[`ST_INX] = p.in_exc;
    s[`ST_OUTX] = p.out_exc;
    if (p.rx_data) begin
      s[`ST_LEN] = (p.rx_len != {1'b0, p.armed});
      s[`ST_OVF] = (p.rx_len > {1'b0, p.armed});
      s[`ST_UNF] = (p.rx_len < {1'b0, p.armed});
    end
    return s;
  endfunction : status_word

  // endpoint memory window decode, used by read and write paths
  function automatic logic is_ep(input logic [15:0] a);
    return (a & `EP_REGION_MASK) == `EP_BASE_OFS;
  endfunction : is_ep

  // flop-held register read mux, unmapped reads zero
  function automatic logic [15:0] reg_read(input logic [15:0] a, input ctl_t s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      `PORT_CHOICE1_OFS: v = s.port[0];
      `IRQ_EN1_OFS: v = s.irqen[0];
      `PORT_CHOICE2_OFS: v = s.port[1];
      `IRQ_EN2_OFS: v = s.irqen[1];
      `SOF_PERIOD1_OFS: v = s.period[0];
      `SOF_PERIOD2_OFS: v = s.period[1];
      `FRAME_CNT1_OFS: v = s.frame[0];
      `FRAME_CNT2_OFS: v = s.frame[1];
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : reg_read

  // vbus and id pins of the first engine's primary port
  usb_pin_edge #(
    .W(2)
  ) u_pins (
    .clk(clk),
    .srst(srst),
    .pin_in({vbus_valid_pin, otg_id_pin}),
    .level(pin_level),
    .edge_pulse(pin_edge)
  );

  usb_ep_mem #(
    .AW(4),
    .DW(32)
  ) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

  assign accept = hsel & htrans[1] & hready;
  assign overflow = pkt.valid & pkt.rx_data & (pkt.rx_len > {1'b0, pkt.armed});
  assign underflow = pkt.valid & pkt.rx_data & (pkt.rx_len < {1'b0, pkt.armed});
  assign done_evt = pkt.ack | pkt.stall | pkt.timeout | pkt.in_exc | pkt.out_exc
                  | (pkt.nak & pkt.nak_irq_en);

  // hold the read address steady while the data phase waits
  assign mem_raddr = (st_q.bus == bus_wait) ? st_q.addr[6:3] : haddr[6:3];

  // engine write wins the memory; a bus write waits for a free cycle
  always_comb begin
    mem_we = 2'b00;
    mem_waddr = st_q.addr[6:3];
    mem_wdata = {hwdata[15:0], hwdata[15:0]};
    if (pkt.valid) begin
      mem_we = {1'b1, pkt.rx_data};
      mem_waddr = {pkt.engine, pkt.ep};
      mem_wdata = {status_word(pkt), len_diff(pkt.armed, pkt.rx_len)};
    end else if (st_q.bus == bus_wait && st_q.wr && is_ep(st_q.addr)) begin
      mem_we = st_q.addr[2] ? 2'b10 : 2'b01;
    end
  end

  // sof/eop watchdog hit per engine
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      tmo_hit[e] = !evt[e].sof_eop_seen && st_q.period[e] != 16'h0000
                && st_q.tmo[e] >= st_q.period[e] - 16'h0001;
    end
  end

  // next state of bus slave, registers, watchdogs and request pulses
  always_comb begin
    st_d = st_q;
    unique case (st_q.bus)
      bus_idle, bus_done: begin
        if (accept) begin
          st_d.bus = bus_wait;
          st_d.wr = hwrite;
          st_d.addr = haddr[15:0];
        end else begin
          st_d.bus = bus_idle;
        end
      end
      bus_wait: begin
        if (!(pkt.valid && st_q.wr)) begin
          st_d.bus = bus_done;
          if (is_ep(st_q.addr)) begin
            st_d.rdata = {16'h0000, st_q.addr[2] ? mem_rdata[31:16] : mem_rdata[15:0]};
          end else begin
            st_d.rdata = {16'h0000, reg_read(st_q.addr, st_q)};
          end
          if (st_q.wr) begin
            st_d.rdata = 32'h0000_0000;
            unique case (st_q.addr)
              `PORT_CHOICE1_OFS: st_d.port[0] = hwdata[15:0] & `PORT_CHOICE_MASK;
              `PORT_CHOICE2_OFS: st_d.port[1] = hwdata[15:0] & `PORT_CHOICE_MASK;
              `IRQ_EN1_OFS: st_d.irqen[0] = hwdata[15:0] & `IRQ_EN1_MASK;
              `IRQ_EN2_OFS: st_d.irqen[1] = hwdata[15:0] & `IRQ_EN2_MASK;
              `SOF_PERIOD1_OFS: st_d.period[0] = hwdata[15:0];
              `SOF_PERIOD2_OFS: st_d.period[1] = hwdata[15:0];
              default: ;
            endcase
          end
        end
      end
      default: st_d.bus = bus_idle;
    endcase
    for (int e = 0; e < 2; e++) begin
      // frame count restarts on each received sof/eop
      if (evt[e].sof_eop_seen) begin
        st_d.tmo[e] = 16'h0000;
        st_d.frame[e] = 16'h0000;
      end else if (tmo_hit[e]) begin
        st_d.tmo[e] = 16'h0000;
        st_d.frame[e] = st_q.frame[e] + 16'h0001;
      end else if (st_q.period[e] != 16'h0000) begin
        st_d.tmo[e] = st_q.tmo[e] + 16'h0001;
      end
      // every request gated by its own enable bit
      st_d.irq[e].sof_tmo = tmo_hit[e] & st_q.irqen[e][`IRQ_SOF_TMO_BIT];
      st_d.irq[e].sof_rx = evt[e].sof_eop_seen & st_q.irqen[e][`IRQ_SOF_RX_BIT];
      st_d.irq[e].bus_rst = evt[e].bus_reset & st_q.irqen[e][`IRQ_BUS_RST_BIT];
      for (int p = 0; p < 8; p++) begin
        st_d.irq[e].ep_done[p] = pkt.valid && pkt.engine == e[0] && pkt.ep == p[2:0]
                              && done_evt && st_q.irqen[e][p];
      end
    end
    // otg edges exist only on the first engine
    st_d.irq[0].vbus = pin_edge[1] & st_q.irqen[0][`IRQ_VBUS_BIT];
    st_d.irq[0].id = pin_edge[0] & st_q.irqen[0][`IRQ_ID_BIT];
    st_d.irq[1].vbus = 1'b0;
    st_d.irq[1].id = 1'b0;
  end

  // all enables, selects and counters clear on reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.bus <= bus_idle;
      st_q.period <= {`SOF_PERIOD_RESET, `SOF_PERIOD_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign hreadyout = (st_q.bus != bus_wait);
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign port_sel_b = {st_q.port[1][`PORT_SEL_BIT], st_q.port[0][`PORT_SEL_BIT]};
  assign irq_req = st_q.irq;

  // checks
  sequence port1_write_s;
    st_q.bus == bus_wait && st_q.wr && st_q.addr == `PORT_CHOICE1_OFS && !pkt.valid;
  endsequence

  sequence tmo_hit0_s;
    tmo_hit[0] && !srst;
  endsequence

  property port_follows_p;
    @(posedge clk) disable iff (srst) port1_write_s |=> port_sel_b[0] == $past(hwdata[14]);
  endproperty

  property frame_count_p;
    @(posedge clk) disable iff (srst) tmo_hit0_s |=> st_q.frame[0] == $past(st_q.frame[0]) + 16'h0001;
  endproperty

  diff_write_a: assert property (@(posedge clk) disable iff (srst)
    pkt.valid && pkt.rx_data |-> mem_we == 2'b11 && mem_waddr == {pkt.engine, pkt.ep})
    else $error("result word not written for received packet");
  len_flag_a: assert property (@(posedge clk) disable iff (srst)
    pkt.valid && pkt.rx_data && pkt.rx_len != {1'b0, pkt.armed} |-> mem_wdata[16 + `ST_LEN])
    else $error("length exception flag missing");
  ovf_sign_a: assert property (@(posedge clk) disable iff (srst)
    overflow |-> mem_wdata[15:10] == 6'h3f && mem_wdata[16 + `ST_OVF] && !mem_wdata[16 + `ST_UNF])
    else $error("overflow result not negative");
  unf_value_a: assert property (@(posedge clk) disable iff (srst)
    underflow |-> mem_wdata[15:0] == {6'h00, pkt.armed} - {5'h00, pkt.rx_len} && mem_wdata[16 + `ST_UNF])
    else $error("underflow result wrong");
  port_select_a: assert property (port_follows_p)
    else $error("port select not following write");
  irq_reset_a: assert property (@(posedge clk) srst |=> st_q.irqen == 32'h0000_0000 && port_sel_b == 2'b00)
    else $error("enables not cleared by reset");
  second_otg_a: assert property (@(posedge clk) disable iff (srst) !irq_req[1].vbus && !irq_req[1].id)
    else $error("otg request on second engine");
  frame_count_a: assert property (frame_count_p)
    else $error("frame counter missed a timeout");
  sof_gate_a: assert property (@(posedge clk) disable iff (srst)
    irq_req[0].sof_rx |-> $past(evt[0].sof_eop_seen) && $past(st_q.irqen[0][9]))
    else $error("sof request without enable");
  rst_gate_a: assert property (@(posedge clk) disable iff (srst)
    evt[1].bus_reset && st_q.irqen[1][8] |=> irq_req[1].bus_rst)
    else $error("bus reset request lost");
  ep_done_a: assert property (@(posedge clk) disable iff (srst)
    pkt.valid && !pkt.engine && pkt.ep == 3'h0 && pkt.ack && st_q.irqen[0][0] |=> irq_req[0].ep_done[0])
    else $error("endpoint done request lost");
  bus_wait_a: assert property (@(posedge clk) disable iff (srst)
    accept |=> !hreadyout ##[1:8] hreadyout)
    else $error("bus transfer not answered");

  // otg edges: request one cycle after the synchroniser sees the level move
  sequence vbus_edge_s;
    pin_edge[1] && st_q.irqen[0][`IRQ_VBUS_BIT];
  endsequence

  sequence id_edge_s;
    pin_edge[0] && st_q.irqen[0][`IRQ_ID_BIT];
  endsequence

  property vbus_req_p;
    @(posedge clk) disable iff (srst) vbus_edge_s |=> irq_req[0].vbus && $changed(pin_level[1]);
  endproperty

  property id_req_p;
    @(posedge clk) disable iff (srst) id_edge_s |=> irq_req[0].id && $changed(pin_level[0]);
  endproperty

  vbus_edge_a: assert property (vbus_req_p)
    else $error("vbus edge request lost");
  id_edge_a: assert property (id_req_p)
    else $error("id edge request lost");

  // watchdog requests both ways: a hit raises one, none without its enable; then frame clear on sof and the endpoint enable gate
  tmo_req_a: assert property (@(posedge clk) disable iff (srst)
    tmo_hit[0] && st_q.irqen[0][`IRQ_SOF_TMO_BIT] |=> irq_req[0].sof_tmo)
    else $error("timeout request lost");
  tmo_gate_a: assert property (@(posedge clk) disable iff (srst)
    irq_req[0].sof_tmo |-> $past(tmo_hit[0]) && $past(st_q.irqen[0][`IRQ_SOF_TMO_BIT]))
    else $error("timeout request without enable");
  frame_clear_a: assert property (@(posedge clk) disable iff (srst)
    evt[0].sof_eop_seen |=> st_q.frame[0] == 16'h0000)
    else $error("frame counter not cleared by sof");
  ep_gate_a: assert property (@(posedge clk) disable iff (srst)
    irq_req[1].ep_done[7] |-> $past(st_q.irqen[1][7]))
    else $error("endpoint request without enable");

  // exact length: no exception flags and a zero result
  len_equal_a: assert property (@(posedge clk) disable iff (srst)
    pkt.valid && pkt.rx_data && pkt.rx_len == {1'b0, pkt.armed}
    |-> mem_wdata[15:0] == 16'h0000 && !mem_wdata[16 + `ST_LEN]
    && !mem_wdata[16 + `ST_OVF] && !mem_wdata[16 + `ST_UNF])
    else $error("exception on exact length");
  // writes answer with zero read data
  wr_zero_a: assert property (@(posedge clk) disable iff (srst)
    st_q.bus == bus_wait && st_q.wr && !pkt.valid |=> hrdata == 32'h0000_0000)
    else $error("write left read data");

endmodule : usb_dev_regblock

/* usb_dev_regs.svh */
// register offsets, field positions and reset values for the usb device register block
// assumes byte addresses on a 32-bit bus, one aligned word per register, 16-bit data in the low bits
//
// Behaviour
// - each received packet writes armed count minus received length into its 16-bit result word
// - a received length unequal to the armed count sets the length-exception status flag
// - overflow stores a negative two's-complement result with bits 15:10 all ones
// - underflow stores the count of armed bytes left unused in all 16 bits
// - port-select bit 14 one picks the secondary port, zero (reset) the primary
// - interrupt-enable bits 7:0 enable endpoints 7..0; every enable resets to zero
// - bit 15 enables vbus edge interrupts, first engine only, reserved in second
// - bit 14 enables id pin edge interrupts, first engine only, reserved in second
// - bit 11 enables a timeout interrupt when no sof/eop arrives within the period
// - a frame counter counts timeouts since the last received sof or eop
// - bit 9 gates the sof/eop received interrupt
// - bit 8 gates the usb bus reset interrupt
// - transaction done on ack, stall, timeout, in/out exception, or nak when enabled
// - a length exception also sets status bit 11 on overflow or bit 10 on underflow
`ifndef USB_DEV_REGS_SVH
`define USB_DEV_REGS_SVH

// register byte offsets
`define PORT_CHOICE1_OFS 16'hc084
`define IRQ_EN1_OFS 16'hc08c
`define PORT_CHOICE2_OFS 16'hc0a4
`define IRQ_EN2_OFS 16'hc0ac
`define SOF_PERIOD1_OFS 16'hc200
`define SOF_PERIOD2_OFS 16'hc204
`define FRAME_CNT1_OFS 16'hc208
`define FRAME_CNT2_OFS 16'hc20c
`define EP_BASE_OFS 16'hc300
`define EP_REGION_MASK 16'hff80

// writable bits of each word
`define PORT_CHOICE_MASK 16'h4000
`define IRQ_EN1_MASK 16'hcbff
`define IRQ_EN2_MASK 16'h0bff

// field positions
`define PORT_SEL_BIT 14
`define IRQ_VBUS_BIT 15
`define IRQ_ID_BIT 14
`define IRQ_SOF_TMO_BIT 11
`define IRQ_SOF_RX_BIT 9
`define IRQ_BUS_RST_BIT 8
`define ST_OVF 11
`define ST_UNF 10
`define ST_OUTX 9
`define ST_INX 8
`define ST_STALL 7
`define ST_NAK 6
`define ST_LEN 5
`define ST_SETUP 4
`define ST_SEQ 3
`define ST_TMO 2
`define ST_ERR 1
`define ST_ACK 0

// values
`define OVF_SIGN_ONES 6'h3f
`define REG_RESET 16'h0000
`define SOF_PERIOD_RESET 16'h0000

`endif

/* usb_dev_pkg.sv */
// types shared by the usb device register block and its helpers
// assumes the offsets and field positions come from usb_dev_regs.svh
package usb_dev_pkg;

  // bus slave phases
  typedef enum logic [1:0] {bus_idle, bus_wait, bus_done} bus_state_t;

  // one finished transaction, reported by the serial engine for one cycle
  typedef struct packed {
    logic valid;
    logic engine;
    logic [2:0] ep;
    logic rx_data;
    logic [9:0] armed;
    logic [10:0] rx_len;
    logic error;
    logic ack;
    logic stall;
    logic nak;
    logic nak_irq_en;
    logic timeout;
    logic in_exc;
    logic out_exc;
    logic setup;
    logic seq;
  } pkt_rpt_t;

  // per-engine line events from the serial engine
  typedef struct packed {
    logic sof_eop_seen;
    logic bus_reset;
  } engine_evt_t;

  // per-engine interrupt request pulses
  typedef struct packed {
    logic vbus;
    logic id;
    logic sof_tmo;
    logic sof_rx;
    logic bus_rst;
    logic [7:0] ep_done;
  } irq_t;

endpackage : usb_dev_pkg

/* usb_ep_mem.sv */
// endpoint memory: status word in the upper half, result word in the lower half
// assumes one writer per cycle; contents are undefined until firmware clears them
`timescale 1ns/100ps
module usb_ep_mem #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  // clock
  input wire logic clk,
  // write port, one enable per half word
  input wire logic [1:0] we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // half-word writes and registered read
  always_ff @(posedge clk) begin
    if (we[0]) begin
      mem[waddr][DW/2-1:0] <= wdata[DW/2-1:0];
    end
    if (we[1]) begin
      mem[waddr][DW-1:DW/2] <= wdata[DW-1:DW/2];
    end
    rdata_q <= mem[raddr];
  end

endmodule : usb_ep_mem

/* usb_pin_edge.sv */
// pin synchroniser with edge detection, both edges reported as one-cycle pulses
// assumes pins are asynchronous to clk and change slower than a few cycles
`timescale 1ns/100ps
module usb_pin_edge #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // raw pins
  input wire logic [W-1:0] pin_in,
  // synchronised level and edge pulses
  output logic [W-1:0] level,
  output logic [W-1:0] edge_pulse
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges seen between the settled stages only
  assign level = st_q.s3;
  assign edge_pulse = st_q.s2 ^ st_q.s3;

endmodule : usb_pin_edge

/* usb_host_model.sv */
// far-side model: host traffic as the serial engine reports it to the register block
// assumes bench commands change right after a rising edge of clk
`timescale 1ns/100ps
module usb_host_model
  import usb_dev_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench commands
  input wire logic go,
  input wire pkt_rpt_t req,
  input wire logic [1:0] sof_go,
  input wire logic [1:0] rst_go,
  input wire logic [7:0] sof_gap,
  // reports toward the block
  output pkt_rpt_t pkt,
  output engine_evt_t [1:0] evt
);
  logic [7:0] cnt_q;
  logic frame_due;

  // periodic frames on the first engine, 0 stops them
  assign frame_due = (sof_gap != 8'h00) && (cnt_q + 8'h01 >= sof_gap);

  // one-cycle reports; idle fields flip so stale values never look valid
  always_ff @(posedge clk) begin
    if (srst) begin
      pkt <= '0;
      evt <= '0;
      cnt_q <= 8'h00;
    end else begin
      pkt <= {go, go ? req[$bits(pkt_rpt_t)-2:0] : ~req[$bits(pkt_rpt_t)-2:0]};
      cnt_q <= frame_due ? 8'h00 : cnt_q + 8'h01;
      evt[0].sof_eop_seen <= sof_go[0] || frame_due;
      evt[1].sof_eop_seen <= sof_go[1];
      evt[0].bus_reset <= rst_go[0];
      evt[1].bus_reset <= rst_go[1];
    end
  end
endmodule : usb_host_model

/* testbench.sv */
// self-checking bench for the usb device register block
// assumes the host model beside it and the register map header
`timescale 1ns/100ps
`include "usb_dev_regs.svh"
module testbench
  import usb_dev_pkg::*;
;
  typedef irq_t [1:0] irq_pair_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  pkt_rpt_t pkt;
  pkt_rpt_t req = '0;
  engine_evt_t [1:0] evt;
  logic go = 1'b0;
  logic [1:0] rst_go = '0;
  logic [1:0] sof_go = '0;
  logic [7:0] sof_gap = '0;
  logic vbus_pin = 1'b0;
  logic id_pin = 1'b0;
  logic [1:0] port_sel_b;
  irq_pair_t irq_req;
  logic rd_dp = 1'b0;
  logic [31:0] exp_rd[$];
  irq_pair_t exp_irq[$];
  int miscompares = 0;
  int n_tests = 0;
  int tmo_n = 0;
  logic [15:0] ofs [4] = '{`PORT_CHOICE1_OFS, `IRQ_EN1_OFS, `PORT_CHOICE2_OFS, `IRQ_EN2_OFS};
  logic [15:0] msk [4] = '{`PORT_CHOICE_MASK, `IRQ_EN1_MASK, `PORT_CHOICE_MASK, `IRQ_EN2_MASK};

  always #4 clk = ~clk;

  usb_dev_regblock u_usb_dev_regblock (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pkt(pkt), .evt(evt), .vbus_valid_pin(vbus_pin), .otg_id_pin(id_pin),
    .port_sel_b(port_sel_b), .irq_req(irq_req));
  usb_host_model u_usb_host_model (.clk(clk), .srst(srst), .go(go), .req(req), .sof_go(sof_go),
    .rst_go(rst_go), .sof_gap(sof_gap), .pkt(pkt), .evt(evt));

  task automatic miss(input string msg);
    miscompares++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : miss
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) miss($sformatf("word %h expected %h", got, exp));
  endtask : check_word
  task automatic check_irq(input irq_pair_t got, input irq_pair_t exp);
    n_tests++;
    if (got !== exp) miss($sformatf("interrupts %h expected %h", got, exp));
  endtask : check_irq
  task automatic end_sim;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // settled ready seen at the falling edge means the next rising edge completes
  task automatic wait_rdy;
    int i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 40);
    if (hreadyout !== 1'b1) begin
      miss("bus wait ran out");
      end_sim;
    end
    @(posedge clk);
  endtask : wait_rdy
  // single word transfer; returns on the completing edge so the next may follow at once
  task automatic bus_xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {16'h0000, a};
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask : bus_xfer
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_xfer(1'b1, a, {16'h0000, d});
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_rd.push_back({16'h0000, e});
    bus_xfer(1'b0, a, '0);
  endtask : rd

  // watcher: oldest note against each finished read and each interrupt pulse except sof_tmo, which is only counted
  always @(posedge clk) begin
    irq_pair_t m;
    if (rd_dp && hreadyout === 1'b1) begin
      check_word(32'(hresp), 32'h0);
      if (exp_rd.size() == 0) miss("read not expected");
      else check_word(hrdata, exp_rd.pop_front());
    end
    if (hreadyout === 1'b1) rd_dp = hsel && htrans[1] && !hwrite;
    m = irq_req;
    tmo_n += int'(m[0].sof_tmo) + int'(m[1].sof_tmo);
    m[0].sof_tmo = 1'b0;
    m[1].sof_tmo = 1'b0;
    if (!srst && m !== '0) begin
      if (exp_irq.size() == 0) miss("interrupt not expected");
      else check_irq(m, exp_irq.pop_front());
    end
  end

  // main sequence
  initial begin
    irq_pair_t e;
    pkt_rpt_t r;
    logic [15:0] sts;
    logic [15:0] res_m [16];
    logic [15:0] en [2];
    logic ovf;
    logic unf;
    int idx;
    void'($urandom(32'h6ce85ecd));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values, then every writable bit set with reserved bits kept zero
    for (int k = 0; k < 4; k++) rd(ofs[k], 16'h0000);
    for (int k = 0; k < 4; k++) wr(ofs[k], msk[k]);
    for (int k = 0; k < 4; k++) rd(ofs[k], msk[k]);
    check_word(32'(port_sel_b), 32'h3);
    for (int k = 0; k < 4; k++) wr(ofs[k], 16'h0000);
    check_word(32'(port_sel_b), 32'h0);
    wr(16'hc100, 16'hffff);
    rd(16'hc100, 16'h0000);
    // firmware zeroes every endpoint word before traffic
    for (int k = 0; k < 32; k++) wr(`EP_BASE_OFS + 16'(4 * k), 16'h0000);
    for (int k = 0; k < 16; k++) res_m[k] = 16'h0000;
    en[0] = 16'($urandom_range(0, 255));
    en[1] = 16'($urandom_range(0, 255));
    wr(`IRQ_EN1_OFS, en[0]);
    wr(`IRQ_EN2_OFS, en[1]);
    // random packets: equal, short and long against the armed count
    for (int n = 0; n < 40; n++) begin
      r = $bits(pkt_rpt_t)'({$urandom(), $urandom()});
      r.valid = 1'b1;
      r.armed = 10'($urandom_range(0, 1023));
      case ($urandom_range(0, 2))
        0: r.rx_len = 11'(r.armed);
        1: r.rx_len = 11'($urandom_range(0, r.armed));
        default: r.rx_len = 11'(r.armed) + 11'($urandom_range(1, 1023));
      endcase
      idx = {r.engine, r.ep};
      if (r.rx_data) res_m[idx] = 16'(r.armed) - 16'(r.rx_len);
      ovf = r.rx_data && r.rx_len > 11'(r.armed);
      unf = r.rx_data && r.rx_len < 11'(r.armed);
      if (ovf) res_m[idx][15:10] = 6'h3f;
      sts = {4'h0, ovf, unf, r.out_exc, r.in_exc, r.stall, r.nak, ovf | unf,
        r.setup, r.seq, r.timeout, r.error, r.ack};
      e = '0;
      e[r.engine].ep_done[r.ep] = en[r.engine][r.ep] && (r.ack || r.stall || r.timeout || r.in_exc || r.out_exc
        || (r.nak && r.nak_irq_en));
      if (e !== '0) exp_irq.push_back(e);
      req <= r;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      rd(`EP_BASE_OFS + 16'(8 * idx), res_m[idx]);
      rd(`EP_BASE_OFS + 16'(8 * idx) + 16'h0004, sts);
    end
    // line events: frame start gated off on the second engine
    wr(`IRQ_EN1_OFS, 16'h0300);
    wr(`IRQ_EN2_OFS, 16'h0100);
    e = '0;
    e[0].sof_rx = 1'b1;
    e[0].bus_rst = 1'b1;
    e[1].bus_rst = 1'b1;
    exp_irq.push_back(e);
    sof_go <= 2'b11;
    rst_go <= 2'b11;
    @(posedge clk);
    sof_go <= 2'b00;
    rst_go <= 2'b00;
    repeat (4) @(posedge clk);
    // both pin edges while enabled, none once disabled
    wr(`IRQ_EN1_OFS, 16'hc000);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) wr(`IRQ_EN1_OFS, 16'h0000);
      e = '0;
      e[0].vbus = (k < 4) && (k % 2 == 0);
      e[0].id = (k < 4) && (k % 2 == 1);
      if (e !== '0) exp_irq.push_back(e);
      if (k % 2 == 0) vbus_pin <= ~vbus_pin;
      else id_pin <= ~id_pin;
      repeat (10) @(posedge clk);
    end
    // frame timeout: none while frames flow, three after they stop
    wr(`IRQ_EN1_OFS, 16'h0800);
    wr(`SOF_PERIOD1_OFS, 16'h0014);
    sof_gap <= 8'h0a;
    repeat (100) @(posedge clk);
    check_word(32'(tmo_n), 32'h0);
    rd(`FRAME_CNT1_OFS, 16'h0000);
    sof_gap <= 8'h00;
    sof_go <= 2'b01;
    @(posedge clk);
    sof_go <= 2'b00;
    repeat (70) @(posedge clk);
    rd(`FRAME_CNT1_OFS, 16'h0003);
    check_word(32'(tmo_n), 32'h3);
    wr(`SOF_PERIOD1_OFS, 16'h0000);
    wr(`FRAME_CNT1_OFS, 16'hffff);
    rd(`FRAME_CNT1_OFS, 16'h0003);
    sof_go <= 2'b01;
    @(posedge clk);
    sof_go <= 2'b00;
    repeat (3) @(posedge clk);
    rd(`FRAME_CNT1_OFS, 16'h0000);
    repeat (5) @(posedge clk);
    check_word(32'(exp_irq.size() + exp_rd.size()), 32'h0);
    end_sim;
  end
endmodule : testbench
